/* hw/safety_interlock_latch.sv */
// Safety interlock latch with APB status, control and event interrupt
//
// Function
// R1 - No pendant and no dummy plug connected forces emergency stop.
// R2 - Strap A grounded, B open: programming mode; A open, B grounded: disabled.
// R3 - Dead-man enable counts only while programming mode is selected.
// R4 - Pendant emergency stop acts in every mode.
// R5 - Dummy plug: pendant stop and mode ignored; no motion with door open.
// R6 - Door channels differing two seconds or longer raise a critical error.
// R7 - Door opening causes program hold and operation prohibit.
// R8 - Release input open latches door-open and programming-mode conditions.
// R9 - Release input closed clears the latched conditions.
// R10 - Programming latch released with door open still prohibits operation.
// R11 - Operator closes door first, then closes release input.
// R12 - Release input closed: door condition follows door input directly.
// R13 - Programming latch changes only after deselect then release closed.
// R14 - Switch inputs are synchronised; two-second window counted in clock cycles.
// R15 - Emergency stop channels differing two seconds or longer raise an error.
`timescale 1ns/1ps
module safety_interlock_latch #(
    parameter int MISMATCH_CYCLES = interlock_pkg::MISMATCH_CYCLES,
    parameter int CNT_W = interlock_pkg::MISMATCH_CNT_W
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pendant connector
    input wire logic pendant_present,
    input wire logic dummy_plug_present,
    input wire logic mode_strap_a,
    input wire logic mode_strap_b,
    input wire logic deadman_enable,
    input wire logic pendant_estop_ch1_a,
    input wire logic pendant_estop_ch2_a,
    // Emergency connector
    input wire logic estop_ch1_closed,
    input wire logic estop_ch2_closed,
    input wire logic door_ch1_closed,
    input wire logic door_ch2_closed,
    input wire logic latch_release_closed,
    // Interlock outputs
    output logic estop_active,
    output logic door_open_latched,
    output logic programming_mode_latched,
    output logic program_hold,
    output logic operation_prohibit,
    output logic door_mismatch_err,
    output logic estop_mismatch_err,
    output logic irq
);
    import interlock_pkg::*;

    // ==================================================
    // Input synchronisers
    localparam int IN_W = 12;
    // Doors read closed until primed, else every reset latches a false opening; stop still holds
    localparam logic [IN_W-1:0] SYNC_RESET = 12'h006;
    logic [IN_W-1:0] raw_in;
    logic [IN_W-1:0] sync1_reg;
    logic [IN_W-1:0] sync2_reg;

    assign raw_in = {pendant_present, dummy_plug_present, mode_strap_a, mode_strap_b, deadman_enable,
                     pendant_estop_ch1_a, pendant_estop_ch2_a, estop_ch1_closed, estop_ch2_closed,
                     door_ch1_closed, door_ch2_closed, latch_release_closed};

    // Two stages on every switch before any latch or timer [R14]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= SYNC_RESET;
            sync2_reg <= SYNC_RESET;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    logic pendant_s, dummy_s, strap_a_s, strap_b_s, deadman_s, pest1_s, pest2_s;
    logic est1_s, est2_s, door1_s, door2_s, release_s;
    assign {pendant_s, dummy_s, strap_a_s, strap_b_s, deadman_s, pest1_s, pest2_s,
            est1_s, est2_s, door1_s, door2_s, release_s} = sync2_reg;

    // ==================================================
    // Condition decode
    logic connected_s, prog_sel_s, pendant_stop_s, door_open_s, door_mis_s, estop_mis_s;
    assign connected_s = pendant_s | dummy_s; // [R1]
    // Grounded strap reads low; dummy plug masks the straps [R2] [R5]
    assign prog_sel_s = pendant_s & ~strap_a_s & strap_b_s;
    // Pendant stop is ignored with the dummy plug fitted [R4] [R5]
    assign pendant_stop_s = pendant_s & ~(pest1_s & pest2_s);
    // Either channel open counts as open: the safe reading of a mismatch
    assign door_open_s = ~(door1_s & door2_s);
    assign door_mis_s = door1_s ^ door2_s;
    assign estop_mis_s = est1_s ^ est2_s;

    // ==================================================
    // Mismatch timers
    function automatic logic [CNT_W-1:0] mis_count(input logic mis, input logic [CNT_W-1:0] cnt);
        if (!mis) begin
            mis_count = '0;
        end else if (cnt >= CNT_W'(MISMATCH_CYCLES)) begin
            mis_count = cnt;
        end else begin
            mis_count = cnt + 1'b1;
        end
    endfunction

    logic [CNT_W-1:0] door_cnt_reg, door_cnt_next, estop_cnt_reg, estop_cnt_next;
    logic door_err_reg, door_err_next, estop_err_reg, estop_err_next;

    always_comb begin
        door_cnt_next = mis_count(door_mis_s, door_cnt_reg); // [R6]
        estop_cnt_next = mis_count(estop_mis_s, estop_cnt_reg); // [R15]
        door_err_next = door_cnt_next >= CNT_W'(MISMATCH_CYCLES); // [R6]
        estop_err_next = estop_cnt_next >= CNT_W'(MISMATCH_CYCLES); // [R15]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            door_cnt_reg <= '0;
            estop_cnt_reg <= '0;
            door_err_reg <= 1'b0;
            estop_err_reg <= 1'b0;
        end else begin
            door_cnt_reg <= door_cnt_next;
            estop_cnt_reg <= estop_cnt_next;
            door_err_reg <= door_err_next;
            estop_err_reg <= estop_err_next;
        end
    end

    // ==================================================
    // Latches and interlock outputs
    logic hold_reg;
    logic door_lat_reg, door_lat_next, prog_lat_reg, prog_lat_next;
    logic estop_reg, estop_next, prohibit_reg, prohibit_next;

    always_comb begin
        // Open release latches; closed release follows the inputs [R8] [R9] [R12]
        if (release_s) begin
            door_lat_next = door_open_s;
            prog_lat_next = prog_sel_s; // [R13]
        end else begin
            door_lat_next = door_lat_reg | door_open_s; // [R7]
            prog_lat_next = prog_lat_reg | prog_sel_s;
        end
        // Critical channel errors also stop the arm
        estop_next = ~connected_s | pendant_stop_s | ~(est1_s & est2_s) | door_err_next | estop_err_next; // [R1] [R4]
        // Programming mode may move with the door open only under the dead-man;
        // otherwise the door condition decides [R3] [R5] [R10]
        if (prog_lat_next) begin
            prohibit_next = estop_next | hold_reg | ~(prog_sel_s & deadman_s);
        end else begin
            prohibit_next = estop_next | hold_reg | door_lat_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            door_lat_reg <= 1'b0;
            prog_lat_reg <= 1'b0;
            estop_reg <= 1'b1;
            prohibit_reg <= 1'b1;
        end else begin
            door_lat_reg <= door_lat_next;
            prog_lat_reg <= prog_lat_next;
            estop_reg <= estop_next;
            prohibit_reg <= prohibit_next;
        end
    end

    assign estop_active = estop_reg;
    assign door_open_latched = door_lat_reg;
    assign programming_mode_latched = prog_lat_reg;
    assign program_hold = door_lat_reg; // [R7]
    assign operation_prohibit = prohibit_reg;
    assign door_mismatch_err = door_err_reg;
    assign estop_mismatch_err = estop_err_reg;

    // ==================================================
    // APB registers and event interrupt
    logic [EVT_W-1:0] evt_now, evt_prev_reg, evt_stat_reg, evt_stat_next, evt_en_reg, evt_en_next;
    logic hold_next;
    logic wr_acc, rd_acc, unmapped;
    logic [31:0] rdata_next;
    logic [31:0] prdata_reg;
    logic [STATE_W-1:0] state_vec;
    // Same levels as the conditions in reset, so release gives no false edge
    localparam logic [EVT_W-1:0] EVT_PREV_RESET = 5'h01;

    assign evt_now = {estop_err_reg, door_err_reg, prog_lat_reg, door_lat_reg, estop_reg};
    assign state_vec = {prog_sel_s, connected_s, prohibit_reg, evt_now};
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & ~penable & ~pwrite;
    assign unmapped = !(paddr == CTRL_OFFSET || paddr == STATE_OFFSET || paddr == EVT_STATUS_OFFSET ||
                        paddr == EVT_ENABLE_OFFSET || paddr == EVT_CLEAR_OFFSET);
    assign pready = 1'b1;
    assign pslverr = psel & penable & unmapped;
    assign prdata = prdata_reg;
    assign irq = |(evt_stat_reg & evt_en_reg);

    always_comb begin
        hold_next = hold_reg;
        evt_en_next = evt_en_reg;
        evt_stat_next = evt_stat_reg;
        rdata_next = prdata_reg;
        if (wr_acc && paddr == CTRL_OFFSET) begin
            hold_next = pwdata[CTRL_HOLD_BIT];
        end else if (wr_acc && paddr == EVT_ENABLE_OFFSET) begin
            evt_en_next = pwdata[EVT_W-1:0];
        end else if (wr_acc && paddr == EVT_CLEAR_OFFSET) begin
            evt_stat_next = evt_stat_reg & ~pwdata[EVT_W-1:0];
        end
        // A rising condition in the clear cycle still sets its bit
        evt_stat_next = evt_stat_next | (evt_now & ~evt_prev_reg);
        if (rd_acc) begin
            if (paddr == CTRL_OFFSET) begin
                rdata_next = {31'h00000000, hold_reg};
            end else if (paddr == STATE_OFFSET) begin
                rdata_next = {24'h000000, state_vec};
            end else if (paddr == EVT_STATUS_OFFSET) begin
                rdata_next = {27'h0000000, evt_stat_reg};
            end else if (paddr == EVT_ENABLE_OFFSET) begin
                rdata_next = {27'h0000000, evt_en_reg};
            end else begin
                rdata_next = 32'h00000000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_reg <= CTRL_HOLD_RESET;
            evt_en_reg <= EVT_ENABLE_RESET;
            evt_stat_reg <= '0;
            evt_prev_reg <= EVT_PREV_RESET;
            prdata_reg <= 32'h00000000;
        end else begin
            hold_reg <= hold_next;
            evt_en_reg <= evt_en_next;
            evt_stat_reg <= evt_stat_next;
            evt_prev_reg <= evt_now;
            prdata_reg <= rdata_next;
        end
    end

    // ==================================================
    // Assertions
    property p_no_plug;
        @(posedge pclk) disable iff (!presetn) !connected_s |=> estop_reg && prohibit_reg;
    endproperty
    a_no_plug: assert property (p_no_plug) else $error("no plug without stop"); // [R1]

    property p_strap_decode;
        @(posedge pclk) disable iff (!presetn)
            pendant_s && strap_a_s && !strap_b_s && release_s |=> !prog_lat_reg;
    endproperty
    a_strap_decode: assert property (p_strap_decode) else $error("disabled straps gave programming"); // [R2]

    property p_deadman;
        @(posedge pclk) disable iff (!presetn) prog_lat_next && !deadman_s |=> prohibit_reg;
    endproperty
    a_deadman: assert property (p_deadman) else $error("motion without dead-man"); // [R3]

    property p_pendant_stop;
        @(posedge pclk) disable iff (!presetn) pendant_s && !pest1_s |=> estop_reg ##0 prohibit_reg;
    endproperty
    a_pendant_stop: assert property (p_pendant_stop) else $error("pendant stop ignored"); // [R4]

    property p_dummy_door;
        @(posedge pclk) disable iff (!presetn)
            dummy_s && !pendant_s && door_open_s |=> prohibit_reg && (!prog_lat_reg || $past(prog_lat_reg));
    endproperty
    a_dummy_door: assert property (p_dummy_door) else $error("dummy plug motion with door open"); // [R5]

    property p_door_err;
        @(posedge pclk) disable iff (!presetn) $rose(door_err_reg) |-> $past(door_cnt_reg) == CNT_W'(MISMATCH_CYCLES - 1);
    endproperty
    a_door_err: assert property (p_door_err) else $error("door error at wrong time"); // [R6]

    property p_door_err_clear;
        @(posedge pclk) disable iff (!presetn) !door_mis_s |=> !door_err_reg && door_cnt_reg == '0;
    endproperty
    a_door_err_clear: assert property (p_door_err_clear) else $error("door error without mismatch"); // [R6]

    property p_estop_err;
        @(posedge pclk) disable iff (!presetn) estop_err_reg |-> estop_cnt_reg == CNT_W'(MISMATCH_CYCLES) && estop_reg;
    endproperty
    a_estop_err: assert property (p_estop_err) else $error("stop channel error wrong"); // [R15]

    property p_door_hold;
        @(posedge pclk) disable iff (!presetn) door_open_s |=> program_hold && prohibit_reg || prog_lat_reg;
    endproperty
    a_door_hold: assert property (p_door_hold) else $error("door open without hold"); // [R7]

    property p_latch_keep;
        @(posedge pclk) disable iff (!presetn) !release_s [*2] ##0 $past(door_lat_reg) |-> door_lat_reg;
    endproperty
    a_latch_keep: assert property (p_latch_keep) else $error("door latch lost"); // [R8]

    property p_release_follow;
        @(posedge pclk) disable iff (!presetn) release_s |=> door_lat_reg == $past(door_open_s);
    endproperty
    a_release_follow: assert property (p_release_follow) else $error("door latch not following"); // [R12]

    property p_prog_keep;
        @(posedge pclk) disable iff (!presetn) prog_lat_reg && (prog_sel_s || !release_s) |=> prog_lat_reg;
    endproperty
    a_prog_keep: assert property (p_prog_keep) else $error("programming latch dropped early"); // [R13]

    property p_release_door_open;
        @(posedge pclk) disable iff (!presetn) release_s && door_open_s && !prog_sel_s |=> prohibit_reg;
    endproperty
    a_release_door_open: assert property (p_release_door_open) else $error("released with door open"); // [R10]

    c_door_cycle: cover property (@(posedge pclk) disable iff (!presetn) door_lat_reg ##1 !door_lat_reg);
    c_prog_motion: cover property (@(posedge pclk) disable iff (!presetn) prog_lat_reg && !prohibit_reg);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule

/* shared/interlock_pkg.sv */
// Shared constants for the safety interlock latch
package interlock_pkg;
    // ==================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int MISMATCH_TIME_MS = 2000;
    localparam int MISMATCH_CYCLES = MISMATCH_TIME_MS * (1000000 / CLK_PERIOD_NS);
    localparam int MISMATCH_CNT_W = 28;
    // ==================================================
    // Register offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATE_OFFSET = 8'h04;
    localparam logic [7:0] EVT_STATUS_OFFSET = 8'h08;
    localparam logic [7:0] EVT_ENABLE_OFFSET = 8'h0C;
    localparam logic [7:0] EVT_CLEAR_OFFSET = 8'h10;
    // ==================================================
    // Control fields and reset values
    localparam int CTRL_HOLD_BIT = 0;
    localparam logic CTRL_HOLD_RESET = 1'b0;
    localparam int EVT_W = 5;
    localparam logic [EVT_W-1:0] EVT_ENABLE_RESET = 5'h00;
    // ==================================================
    // Event and state bit positions (shared layout)
    localparam int EVT_ESTOP = 0;
    localparam int EVT_DOOR_OPEN = 1;
    localparam int EVT_PROG_MODE = 2;
    localparam int EVT_DOOR_ERR = 3;
    localparam int EVT_ESTOP_ERR = 4;
    localparam int STATE_PROHIBIT = 5;
    localparam int STATE_CONNECTED = 6;
    localparam int STATE_PROG_SEL = 7;
    localparam int STATE_W = 8;
endpackage

/* tb/switch_partner.sv */
// Behavioural pendant, dummy plug and safety-door contacts
`timescale 1ns/1ps
module switch_partner (
    // Commands from the bench
    input wire logic pendant,
    input wire logic plug,
    input wire logic prog_sel,
    input wire logic deadman,
    input wire logic estop_pressed,
    input wire logic door_open,
    input wire logic door_skew,
    // Lines into the interlock
    output logic pendant_present,
    output logic dummy_plug_present,
    output logic mode_strap_a,
    output logic mode_strap_b,
    output logic deadman_enable,
    output logic pendant_estop_ch1_a,
    output logic pendant_estop_ch2_a,
    output logic door_ch1_closed,
    output logic door_ch2_closed
);
    // ==================================================
    // Contacts
    always_comb begin
        pendant_present = pendant;
        dummy_plug_present = plug & !pendant;
        // Open straps float high; only a pendant grounds one of them
        mode_strap_a = pendant ? !prog_sel : 1'b1;
        mode_strap_b = pendant ? prog_sel : 1'b1;
        deadman_enable = pendant & deadman;
        // Plug loops the stop contacts closed; empty socket reads open
        pendant_estop_ch1_a = pendant ? !estop_pressed : plug;
        pendant_estop_ch2_a = pendant ? !estop_pressed : plug;
        // Skew opens channel 1 alone to provoke a mismatch
        door_ch1_closed = !door_open & !door_skew;
        door_ch2_closed = !door_open;
    end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the safety interlock latch
`timescale 1ns/1ps
module testbench;
    import interlock_pkg::*;
    localparam int MIS = 20;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err;
    logic pendant = 1'b0, plug = 1'b1, prog_sel = 1'b0, deadman = 1'b0, estop_pressed = 1'b0;
    logic door_open = 1'b0, door_skew = 1'b0, ext_a = 1'b1, ext_b = 1'b1, release_closed = 1'b1;
    logic pp, dp, sa, sb, de, pe1, pe2, d1, d2;
    logic estop_active, door_open_latched, programming_mode_latched, program_hold;
    logic operation_prohibit, door_mismatch_err, estop_mismatch_err, irq;
    int n_errors = 0, cmp_count = 0, i;
    // Row: pendant plug sel deadman pressed door ext | estop doorl progl prohibit
    logic [10:0] rows [11] = '{11'b0000000_1001, 11'b0100000_0000, 11'b0110100_0000, 11'b0100010_0101,
        11'b1000000_0000, 11'b1010000_0011, 11'b1011000_0010, 11'b1001010_0101, 11'b1011100_1011,
        11'b1000100_1001, 11'b1000001_1001};
    always #5 pclk = ~pclk;
    switch_partner far_side (.pendant(pendant), .plug(plug), .prog_sel(prog_sel), .deadman(deadman),
        .estop_pressed(estop_pressed), .door_open(door_open), .door_skew(door_skew), .pendant_present(pp),
        .dummy_plug_present(dp), .mode_strap_a(sa), .mode_strap_b(sb), .deadman_enable(de),
        .pendant_estop_ch1_a(pe1), .pendant_estop_ch2_a(pe2), .door_ch1_closed(d1), .door_ch2_closed(d2));
    safety_interlock_latch #(.MISMATCH_CYCLES(MIS), .CNT_W(8)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pendant_present(pp), .dummy_plug_present(dp),
        .mode_strap_a(sa), .mode_strap_b(sb), .deadman_enable(de), .pendant_estop_ch1_a(pe1),
        .pendant_estop_ch2_a(pe2), .estop_ch1_closed(ext_a), .estop_ch2_closed(ext_b),
        .door_ch1_closed(d1), .door_ch2_closed(d2), .latch_release_closed(release_closed),
        .estop_active(estop_active), .door_open_latched(door_open_latched),
        .programming_mode_latched(programming_mode_latched), .program_hold(program_hold),
        .operation_prohibit(operation_prohibit), .door_mismatch_err(door_mismatch_err),
        .estop_mismatch_err(estop_mismatch_err), .irq(irq));
    // ==================================================
    // Helpers
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Master holds the request until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                break;
            end
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 20) begin
            n_errors++;
            tally_and_finish();
        end
    endtask
    initial begin
        // ==================================================
        // Reset
        settle(12);
        check({estop_active, operation_prohibit, irq}, 3'b110);
        presetn <= 1'b1;
        apb(1'b0, EVT_ENABLE_OFFSET, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        $display("reset test done");
        // ==================================================
        // Interrupt: raise, mask, clear
        apb(1'b1, EVT_CLEAR_OFFSET, 32'h1F);
        apb(1'b1, EVT_ENABLE_OFFSET, 32'h2);
        check(irq, 1'b0);
        door_open <= 1'b1;
        settle(6);
        check({irq, program_hold, operation_prohibit}, 3'b111);
        apb(1'b0, EVT_STATUS_OFFSET, 32'h0);
        check(rd, 32'h1 << EVT_DOOR_OPEN);
        apb(1'b1, EVT_ENABLE_OFFSET, 32'h0);
        settle(1);
        check(irq, 1'b0);
        apb(1'b1, EVT_ENABLE_OFFSET, 32'h2);
        door_open <= 1'b0;
        settle(5);
        apb(1'b1, EVT_CLEAR_OFFSET, 32'h2);
        apb(1'b0, EVT_STATUS_OFFSET, 32'h0);
        check({irq, rd[EVT_DOOR_OPEN]}, 2'b00);
        apb(1'b1, CTRL_OFFSET, 32'h1);
        settle(2);
        check(operation_prohibit, 1'b1);
        apb(1'b1, CTRL_OFFSET, 32'h0);
        settle(2);
        check(operation_prohibit, 1'b0);
        $display("interrupt test done");
        // ==================================================
        // Table of steady cases, release closed so nothing latches
        foreach (rows[i]) begin
            @(posedge pclk);
            {pendant, plug, prog_sel, deadman, estop_pressed, door_open} <= rows[i][10:5];
            ext_a <= !rows[i][4];
            ext_b <= !rows[i][4];
            settle(5);
            check({estop_active, door_open_latched, programming_mode_latched, operation_prohibit},
                rows[i][3:0]);
            check(program_hold, rows[i][2]);
        end
        $display("table test done");
        // ==================================================
        // Latching with release open
        @(posedge pclk);
        {pendant, plug, prog_sel, deadman, estop_pressed, door_open, ext_a, ext_b} <= 8'b10000011;
        release_closed <= 1'b0;
        settle(5);
        door_open <= 1'b1;
        settle(5);
        door_open <= 1'b0;
        prog_sel <= 1'b1;
        settle(5);
        prog_sel <= 1'b0;
        settle(5);
        check({door_open_latched, programming_mode_latched}, 2'b11);
        apb(1'b0, STATE_OFFSET, 32'h0);
        check(rd, (32'h1 << EVT_DOOR_OPEN) | (32'h1 << EVT_PROG_MODE) | (32'h1 << STATE_PROHIBIT) |
            (32'h1 << STATE_CONNECTED));
        door_open <= 1'b1;
        release_closed <= 1'b1;
        settle(5);
        check({door_open_latched, programming_mode_latched, operation_prohibit}, 3'b101);
        door_open <= 1'b0;
        settle(5);
        check({door_open_latched, operation_prohibit}, 2'b00);
        $display("latch test done");
        // ==================================================
        // Redundant channel mismatch, door then stop
        for (i = 0; i < 2; i++) begin
            @(posedge pclk);
            if (i == 0) begin
                door_skew <= 1'b1;
            end else begin
                ext_a <= 1'b0;
            end
            settle(MIS - 2);
            check({door_mismatch_err, estop_mismatch_err}, 2'b00);
            settle(6);
            check({door_mismatch_err, estop_mismatch_err, estop_active}, {i == 0, i == 1, 1'b1});
            door_skew <= 1'b0;
            ext_a <= 1'b1;
            settle(5);
            check({door_mismatch_err, estop_mismatch_err}, 2'b00);
        end
        $display("mismatch test done");
        // ==================================================
        // Second reset with release open and door closed: nothing may latch
        @(posedge pclk);
        release_closed <= 1'b0;
        presetn <= 1'b0;
        settle(2);
        check({estop_active, operation_prohibit, door_open_latched}, 3'b110);
        presetn <= 1'b1;
        settle(6);
        check({door_open_latched, estop_active}, 2'b00);
        apb(1'b0, EVT_STATUS_OFFSET, 32'h0);
        check(rd, 32'h0);
        release_closed <= 1'b1;
        $display("second reset test done");
        tally_and_finish();
    end
endmodule
